// file: logic/sgc_pkg.sv
// sgc_pkg: constants and types for the serial gain control port
// assumes: used by sgc_port and sgc_port_bench only, nothing imported
package sgc_pkg;
   localparam int unsigned WORD_BITS = 8; // bits per gain word on the wire
   localparam int unsigned CODE_BITS = 7; // bits retained by the register
   localparam logic [6:0] CODE_RST = 7'h00; // applied code after reset
   localparam logic [6:0] LIN_TOP = 7'h47; // code 71, top of linear span
   localparam logic [7:0] STEP_QDB = 8'h03; // 0.75 dB step in quarter dB
   localparam logic [7:0] TOP_QDB = 8'h6e; // 27.5 dB in quarter dB
   localparam logic [2:0] VERN_LAST = 3'h7; // last vernier step in group
   localparam int unsigned SYNC_STAGES = 2;
   // sampled link pins travel together
   typedef struct packed {
      logic load_window_n;
      logic serial_clk;
      logic serial_gain_in;
   } sgc_pins_s;
endpackage

// file: logic/sgc_port.sv
// sgc_port: three-wire serial gain port with gain code mapping
// assumes: link pins are asynchronous; serial clock far below clk_sys/4
// Notes on behaviour
// RULE1: controller sends a full eight-bit word
// RULE2: falling load window opens the shift window
// RULE3: sample data on rising clock, msb first
// RULE4: keep seven bits, first bit drops out
// RULE5: rising load window applies the shifted code
// RULE6: codes 0..71 step 0.75 dB linearly
// RULE7: codes 72..127 repeat vernier sawtooth per eight
// RULE8: top bit discarded, upper codes alias lower
// RULE9: clock pulses ignored while window closed
// RULE10: old gain holds while window is open
// RULE11: master on rising, slave on falling edge
// RULE12: gain undefined until controller loads a word; reset applies CODE_RST here
// RULE13: applied code held stable as parallel bus
`timescale 1ns/1ps
`default_nettype none
module sgc_port (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // link pins
   input wire logic load_window_n,
   input wire logic serial_clk,
   input wire logic serial_gain_in,
   // attenuator side
   output logic [6:0] gain_code,
   output logic [7:0] gain_qdb,
   output logic gain_neg,
   output logic gain_update
);
   sgc_pkg::sgc_pins_s pins_raw;
   sgc_pkg::sgc_pins_s pins_s;
   sgc_pkg::sgc_pins_s pins_d_r;
   logic [6:0] slave_r;
   logic [6:0] slave_nxt;
   logic master_r;
   logic [6:0] gain_code_r;
   logic [7:0] mag_nxt;
   logic neg_nxt;
   logic sclk_rise;
   logic sclk_fall;
   logic win_fall;
   logic win_rise;
   logic win_open;
   logic [6:0] lin_code;
   logic [7:0] lin_qdb;
   logic [7:0] top_qdb_lin;

   assign pins_raw = '{load_window_n: load_window_n,
                       serial_clk: serial_clk,
                       serial_gain_in: serial_gain_in};

   sgc_sync #(.WIDTH(3)) u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   // edge detection on synchronised levels only
   assign sclk_rise = pins_s.serial_clk & ~pins_d_r.serial_clk;
   assign sclk_fall = ~pins_s.serial_clk & pins_d_r.serial_clk;
   assign win_fall = ~pins_s.load_window_n & pins_d_r.load_window_n; // RULE2
   assign win_rise = pins_s.load_window_n & ~pins_d_r.load_window_n; // RULE5
   assign win_open = ~pins_s.load_window_n; // RULE9
   // slave takes master on falling clock; msb falls off the top
   assign slave_nxt = {slave_r[5:0], master_r}; // RULE4 RULE11

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pins_d_r <= '{load_window_n: 1'b1, serial_clk: 1'b1,
                       serial_gain_in: 1'b1};
      end else begin
         pins_d_r <= pins_s;
      end
   end

   // master stage samples data on rising serial clock
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         master_r <= 1'b0;
      end else if (win_open && sclk_rise) begin
         master_r <= pins_s.serial_gain_in; // RULE3 RULE11
      end
   end

   // slave shift; a rising edge just before window close still lands
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         slave_r <= sgc_pkg::CODE_RST;
      end else if (win_open && sclk_fall) begin
         slave_r <= slave_nxt; // RULE4 RULE9
      end
   end

   // the shift register after the eighth bit: last bit still in master
   // when the window closes right after a rising edge, so take it too
   // set wins over clear, so a rise in the opening cycle is not lost
   logic pend_r;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pend_r <= 1'b0;
      end else if (win_open && sclk_rise) begin
         pend_r <= 1'b1;
      end else if (win_fall || win_rise || (win_open && sclk_fall)) begin
         pend_r <= 1'b0;
      end
   end
   logic [6:0] load_code;
   assign load_code = pend_r ? slave_nxt : slave_r;

   // applied code changes only on window close; holds meanwhile
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         gain_code_r <= sgc_pkg::CODE_RST; // RULE12
      end else if (win_rise) begin
         gain_code_r <= load_code; // RULE5 RULE8 RULE10
      end
   end

   // update strobe trails the load by one so it lines up with the bus
   logic upd_r;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         upd_r <= 1'b0;
      end else begin
         upd_r <= win_rise; // RULE13
      end
   end

   // gain mapping in quarter dB, sign separate
   assign lin_code = (gain_code_r > sgc_pkg::LIN_TOP) ?
                     {4'h8, gain_code_r[2:0]} : gain_code_r;
   // linear: 27.5 - 0.75*(71-code); vernier: 27.5 - 0.75*(7 - code%8)
   assign lin_qdb = 8'((sgc_pkg::LIN_TOP - lin_code) * sgc_pkg::STEP_QDB);
   assign top_qdb_lin = (gain_code_r > sgc_pkg::LIN_TOP) ?
      8'((sgc_pkg::VERN_LAST - gain_code_r[2:0]) * sgc_pkg::STEP_QDB) :
      lin_qdb; // RULE6 RULE7
   assign neg_nxt = top_qdb_lin > sgc_pkg::TOP_QDB;
   assign mag_nxt = neg_nxt ? 8'(top_qdb_lin - sgc_pkg::TOP_QDB) :
                    8'(sgc_pkg::TOP_QDB - top_qdb_lin);

   // registered outputs to the attenuator
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         gain_code <= sgc_pkg::CODE_RST;
         gain_qdb <= 8'h00;
         gain_neg <= 1'b0;
         gain_update <= 1'b0;
      end else begin
         gain_code <= gain_code_r; // RULE13
         gain_qdb <= mag_nxt;
         gain_neg <= neg_nxt;
         gain_update <= upd_r; // RULE13
      end
   end

   // checks
   property p_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      !win_rise |=> gain_code_r == $past(gain_code_r);
   endproperty
   a_hold: assert property (p_hold) else $error("code moved"); // RULE10

   property p_load;
      @(posedge clk_sys) disable iff (!rst_b)
      win_rise |=> gain_code_r == $past(load_code);
   endproperty
   a_load: assert property (p_load) else $error("code not loaded"); // RULE5

   property p_noshift;
      @(posedge clk_sys) disable iff (!rst_b)
      !win_open |=> slave_r == $past(slave_r);
   endproperty
   a_noshift: assert property (p_noshift) else $error("shift closed"); // RULE9

   property p_shift;
      @(posedge clk_sys) disable iff (!rst_b)
      (win_open && sclk_fall) |=> slave_r[0] == $past(master_r);
   endproperty
   a_shift: assert property (p_shift) else $error("bad shift"); // RULE11

   property p_sample;
      @(posedge clk_sys) disable iff (!rst_b)
      (win_open && sclk_rise) |=> master_r == $past(pins_s.serial_gain_in);
   endproperty
   a_sample: assert property (p_sample) else $error("bad sample"); // RULE3

   property p_out;
      @(posedge clk_sys) disable iff (!rst_b)
      win_rise |-> ##2 gain_code == $past(load_code, 2) && gain_update;
   endproperty
   a_out: assert property (p_out) else $error("bus late"); // RULE13

   property p_max;
      @(posedge clk_sys) disable iff (!rst_b)
      gain_code_r == sgc_pkg::LIN_TOP |=> !gain_neg && gain_qdb == 8'h6e;
   endproperty
   a_max: assert property (p_max) else $error("max gain wrong"); // RULE6

   property p_zero;
      @(posedge clk_sys) disable iff (!rst_b)
      gain_code_r == 7'h00 |=> gain_neg && gain_qdb == 8'h67;
   endproperty
   a_zero: assert property (p_zero) else $error("min gain wrong"); // RULE6

   property p_saw;
      @(posedge clk_sys) disable iff (!rst_b)
      gain_code_r == 7'h48 |=> !gain_neg && gain_qdb == 8'h59;
   endproperty
   a_saw: assert property (p_saw) else $error("vernier wrong"); // RULE7

   property p_pulse;
      @(posedge clk_sys) disable iff (!rst_b)
      gain_update |=> !gain_update;
   endproperty
   a_pulse: assert property (p_pulse) else $error("update too long"); // RULE13

   c_load: cover property (@(posedge clk_sys) win_rise);
   c_stray: cover property (@(posedge clk_sys) !win_open && sclk_rise);
   c_open: cover property (@(posedge clk_sys) win_fall);
   c_saw: cover property (@(posedge clk_sys) gain_code_r == 7'h7f);
endmodule
`default_nettype wire

// file: logic/sgc_sync.sv
// sgc_sync: two-stage synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous to clk_sys; nothing but stage two reads stage one
`timescale 1ns/1ps
`default_nettype none
module sgc_sync #(
   parameter int unsigned WIDTH = 3
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // pins in, synchronised out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   // a bundle of no bits cannot be served
   if (WIDTH < 1) begin : g_bad_width
      $error("sgc_sync needs a width of at least one");
   end
   // second stage alone reads the first
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         meta_r <= '1;
         sync_out <= '1;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// file: test/sgc_host.sv
// sgc_host: behavioural controller on the far side of the gain port
// assumes: tasks are called just after a falling edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module sgc_host (
   // clock
   input wire logic clk_sys,
   // link pins
   output logic load_window_n,
   output logic serial_clk,
   output logic serial_gain_in
);
   // pins start high; serial clock rests high between frames except while pulse runs
   initial begin
      load_window_n = 1'b1;
      serial_clk = 1'b1;
      serial_gain_in = 1'b1;
   end
   // 160 ns per phase keeps a 320 ns serial clock period
   task automatic wait_phase;
      repeat (4) @(negedge clk_sys);
   endtask
   // one frame of n bits, msb first, data set while clock low
   task automatic send(input logic [7:0] w, input int n);
      load_window_n = 1'b0;
      wait_phase();
      for (int i = n - 1; i >= 0; i--) begin
         serial_clk = 1'b0;
         serial_gain_in = w[i];
         wait_phase();
         serial_clk = 1'b1;
         wait_phase();
      end
      serial_gain_in = ~serial_gain_in; // released line must not be trusted
      load_window_n = 1'b1;
   endtask
   // stray pulses with the window closed, data toggling
   task automatic pulse(input int n);
      repeat (n) begin
         serial_clk = 1'b0;
         serial_gain_in = ~serial_gain_in;
         wait_phase();
         serial_clk = 1'b1;
         wait_phase();
      end
   endtask
endmodule
`default_nettype wire

// file: test/sgc_port_bench.sv
// sgc_port_bench: random and corner gain words through the port
// assumes: sgc_host drives the pins, bench owns clock and reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module sgc_port_bench;
   logic clk_sys, rst_b, load_window_n, serial_clk, serial_gain_in;
   logic [6:0] gain_code;
   logic [7:0] gain_qdb;
   logic gain_neg, gain_update;
   logic [6:0] code;
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 32'hf114abb8;
   int cycles = 0;
   logic [7:0] corners [6] = '{8'h00, 8'h47, 8'h48, 8'h7f, 8'hc7, 8'hff};
   sgc_host sgc_host_inst (.clk_sys(clk_sys), .load_window_n(load_window_n),
      .serial_clk(serial_clk), .serial_gain_in(serial_gain_in));
   sgc_port sgc_port_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .load_window_n(load_window_n), .serial_clk(serial_clk),
      .serial_gain_in(serial_gain_in), .gain_code(gain_code),
      .gain_qdb(gain_qdb), .gain_neg(gain_neg), .gain_update(gain_update));
   // expected sign and quarter-dB magnitude of a code
   function automatic logic [8:0] exp_gain(input logic [6:0] c);
      int q;
      q = (c <= 71) ? 110 - 3 * (71 - int'(c)) : 110 - 3 * (7 - int'(c) % 8);
      return {q < 0, (q < 0) ? 8'(-q) : 8'(q)};
   endfunction
   task automatic stop_test;
      if (n_mismatch == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // fewer than eight bits shift onto the old register contents
   task automatic frame(input logic [7:0] w, input int n);
      logic [6:0] old;
      int k;
      old = gain_code;
      code = 7'((code << n) | (w & ((1 << n) - 1)));
      sgc_host_inst.send(w, n);
      `CHK(gain_code, old)
      k = 0;
      while (gain_update !== 1'b1 && k < 12) begin
         @(negedge clk_sys);
         k++;
      end
      `CHK(gain_update, 1'b1)
      `CHK(gain_code, code)
      `CHK({gain_neg, gain_qdb}, exp_gain(code))
      @(negedge clk_sys);
      `CHK(gain_update, 1'b0)
   endtask
   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard, well above the planned run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      rst_b = 1'b0;
      code = sgc_pkg::CODE_RST;
      repeat (4) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      `CHK({gain_neg, gain_qdb, gain_code}, {exp_gain(code), code})
      foreach (corners[i])
         frame(corners[i], 8);
      repeat (30)
         frame(8'($random(seed)), 8);
      frame(8'h05, 3);
      sgc_host_inst.pulse(6);
      repeat (8) @(negedge clk_sys);
      `CHK(gain_code, code)
      frame(8'($random(seed)), 2);
      stop_test();
   end
endmodule
`default_nettype wire
